// [logic/expanded_ctrl_inband_loopback_regs.sv]
// expanded control bank with inband loopback code detection for eight channels
`timescale 1ns/1ps
`include "lb_regs_params.svh"
module expanded_ctrl_inband_loopback_regs #(
    parameter int CHANNELS = 8,
    parameter logic [15:0] MATCH_BITS = `MATCH_BITS_DEF,
    parameter logic [7:0] CLK_LOW_CYC = `CLK_LOW_CYC_DEF
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire lb_regs_pkg::host_req_t host_in,
    output logic [7:0] host_rdata_out,
    input wire logic [CHANNELS-1:0] rx_data_in,
    input wire logic [CHANNELS-1:0] rx_strobe_in,
    input wire logic [CHANNELS-1:0] tx_clock_in,
    output logic [CHANNELS-1:0] clk_recovery_off_out,
    output logic [CHANNELS-1:0] rx_powerdown_out,
    output logic [CHANNELS-1:0] tx_powerdown_out,
    output logic [CHANNELS-1:0] excess_zero_det_en_out,
    output logic [CHANNELS-1:0] code_violation_det_en_out,
    output logic [CHANNELS-1:0] single_ended_term_sel_out,
    output logic [CHANNELS-1:0] ami_sel_out,
    output logic [CHANNELS-1:0] zero_sub_sel_out,
    output logic [CHANNELS-1:0] loop_detect_status_out,
    output logic [CHANNELS-1:0] remote_loop_out,
    output logic loop_irq_out
);
    import lb_regs_pkg::*;

    // elaboration-time guards: the register map holds one bit per channel
    if (CHANNELS != 8) begin : g_bad_channels
        $error("bank is eight channels wide");
    end
    if (MATCH_BITS == 16'h0000) begin : g_bad_match
        $error("MATCH_BITS must be nonzero");
    end
    if (CLK_LOW_CYC == 8'h00) begin : g_bad_low
        $error("CLK_LOW_CYC must be nonzero");
    end

    // top bits of a repeating code that take part in the compare
    function automatic logic [7:0] len_mask(input logic [1:0] len);
        case (len)
            2'b00: len_mask = 8'h1F;
            2'b01: len_mask = 8'h3F;
            2'b10: len_mask = 8'h7F;
            default: len_mask = 8'hFF;
        endcase
    endfunction

    // code aligned so its first bit sits where the oldest window bit is
    function automatic logic [7:0] code_align(input logic [7:0] code, input logic [1:0] len);
        case (len)
            2'b00: code_align = {3'b000, code[7:3]};
            2'b01: code_align = {2'b00, code[7:2]};
            2'b10: code_align = {1'b0, code[7:1]};
            default: code_align = code;
        endcase
    endfunction

    function automatic logic [2:0] oldest_bit(input logic [1:0] len);
        oldest_bit = 3'd4 + {1'b0, len};
    endfunction

    // one address compare, shared by the write strobes and the status read
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        reg_hit = (addr == target);
    endfunction

    // masked compare of the newest window bits against an aligned code
    function automatic logic code_match(input logic [7:0] bits, input logic [7:0] code,
        input logic [7:0] keep);
        code_match = ((bits & keep) == (code & keep));
    endfunction

    // periodic run length; it saturates so a long idle code cannot wrap to zero
    function automatic logic [15:0] run_step(input logic [15:0] run, input logic same);
        if (!same) run_step = 16'h0000;
        else if (run == 16'hFFFF) run_step = run;
        else run_step = run + 16'h0001;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] pointer;
    logic [7:0] single_rail;
    logic [7:0] ami_sel;
    logic [7:0] clk_recovery_off;
    logic [7:0] rpd;
    logic [7:0] tpd;
    logic [7:0] ezd;
    logic [7:0] cvd;
    logic [7:0] term;
    loop_cfg_t cfg;
    logic [7:0] act_code;
    logic [7:0] deact_code;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] irq;
    wire [7:0] next_status;
    wire [7:0] next_irq;
    wire [7:0] clk_low;

    wire expanded = (pointer == `BANK_EXPANDED); // [RQ20]
    wire hit_ptr = (host_in.addr == `ADDR_POINTER);
    wire wr_ptr = host_in.wr && hit_ptr;
    wire wr_x = host_in.wr && expanded && !hit_ptr;
    wire rd_stat = host_in.rd && expanded && reg_hit(host_in.addr, `ADDR_LBSTAT);
    wire [7:0] mask_act = len_mask(cfg.act_len); // [RQ11]
    wire [7:0] mask_deact = len_mask(cfg.deact_len); // [RQ12]
    wire [7:0] ref_act = code_align(act_code, cfg.act_len); // [RQ14]
    wire [7:0] ref_deact = code_align(deact_code, cfg.deact_len); // [RQ15]
    wire [2:0] old_act = oldest_bit(cfg.act_len);
    wire [2:0] old_deact = oldest_bit(cfg.deact_len);
    wire [7:0] cfg_read = {2'b00, cfg}; // [RQ8]
    wire [7:0] mode_ok = single_rail & ~clk_recovery_off; // [RQ21]

    // one write strobe per stored register; status and interrupt are read only
    wire wr_single_rail = wr_x && reg_hit(host_in.addr, `ADDR_SINGLE_RAIL);
    wire wr_code_sel = wr_x && reg_hit(host_in.addr, `ADDR_CODE_SEL);
    wire wr_crs = wr_x && reg_hit(host_in.addr, `ADDR_CRS);
    wire wr_rpd = wr_x && reg_hit(host_in.addr, `ADDR_RPD);
    wire wr_tpd = wr_x && reg_hit(host_in.addr, `ADDR_TPD);
    wire wr_ezd = wr_x && reg_hit(host_in.addr, `ADDR_EZD);
    wire wr_cvd = wr_x && reg_hit(host_in.addr, `ADDR_CVD);
    wire wr_term = wr_x && reg_hit(host_in.addr, `ADDR_TERM);
    wire wr_cfg = wr_x && reg_hit(host_in.addr, `ADDR_LBCFG);
    wire wr_act = wr_x && reg_hit(host_in.addr, `ADDR_ACT);
    wire wr_deact = wr_x && reg_hit(host_in.addr, `ADDR_DEACT);
    wire wr_mask = wr_x && reg_hit(host_in.addr, `ADDR_LBMASK);

    // decoder controls only act in single rail with clock recovery running
    wire [7:0] next_zero_sub = mode_ok & ~ami_sel; // [RQ21]
    wire [7:0] next_ezd_en = ezd & next_zero_sub; // [RQ5]
    wire [7:0] next_cvd_en = ~cvd & next_zero_sub; // [RQ6]
    wire [7:0] next_tx_pd = tpd | clk_low; // [RQ3] [RQ4]

    ////////////////////////////////////////////////////////////////////////////
    // register writes; every reset value is zero, bit n serves channel n
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin // [RQ22]
            pointer <= `BANK_PRIMARY;
            single_rail <= `REG_RESET;
            ami_sel <= `REG_RESET;
            clk_recovery_off <= `REG_RESET;
            rpd <= `REG_RESET;
            tpd <= `REG_RESET;
            ezd <= `REG_RESET;
            cvd <= `REG_RESET;
            term <= `REG_RESET;
            cfg <= '0;
            act_code <= `REG_RESET;
            deact_code <= `REG_RESET;
            mask <= `REG_RESET;
        end else begin
            if (wr_ptr) pointer <= host_in.wdata; // [RQ20]
            if (wr_single_rail) single_rail <= host_in.wdata;
            if (wr_code_sel) ami_sel <= host_in.wdata;
            if (wr_crs) clk_recovery_off <= host_in.wdata; // [RQ1]
            if (wr_rpd) rpd <= host_in.wdata; // [RQ2]
            if (wr_tpd) tpd <= host_in.wdata; // [RQ3]
            if (wr_ezd) ezd <= host_in.wdata; // [RQ5]
            if (wr_cvd) cvd <= host_in.wdata; // [RQ6]
            if (wr_term) term <= host_in.wdata; // [RQ7]
            if (wr_cfg) cfg <= host_in.wdata[`CFG_WIDTH-1:0]; // [RQ9] [RQ10] [RQ13]
            if (wr_act) act_code <= host_in.wdata; // [RQ13]
            if (wr_deact) deact_code <= host_in.wdata; // [RQ13]
            if (wr_mask) mask <= host_in.wdata; // [RQ18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port, one cycle after the read strobe; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_ptr) begin
            rd_mux = pointer;
        end else if (expanded) begin
            case (host_in.addr)
                `ADDR_SINGLE_RAIL: rd_mux = single_rail;
                `ADDR_CODE_SEL: rd_mux = ami_sel;
                `ADDR_CRS: rd_mux = clk_recovery_off;
                `ADDR_RPD: rd_mux = rpd;
                `ADDR_TPD: rd_mux = tpd;
                `ADDR_EZD: rd_mux = ezd;
                `ADDR_CVD: rd_mux = cvd;
                `ADDR_TERM: rd_mux = term;
                `ADDR_LBCFG: rd_mux = cfg_read;
                `ADDR_ACT: rd_mux = act_code;
                `ADDR_DEACT: rd_mux = deact_code;
                `ADDR_LBSTAT: rd_mux = status;
                `ADDR_LBMASK: rd_mux = mask;
                `ADDR_LBIRQ: rd_mux = irq;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // read data holds between reads so a slow host may sample it late
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) host_rdata_out <= 8'h00;
        else if (host_in.rd) host_rdata_out <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel code detector: the stream must repeat with the code's period
    // for MATCH_BITS bits and the newest window must equal the code itself
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_chan
            logic [7:0] win;
            logic [15:0] run_act;
            logic [15:0] run_deact;
            logic [7:0] low_cnt;
            wire bit_in = rx_data_in[ch];
            wire [7:0] next_win = {win[6:0], bit_in};
            wire per_act = (bit_in == win[old_act]);
            wire per_deact = (bit_in == win[old_deact]);
            wire seen_act = code_match(next_win, ref_act, mask_act) && (run_act >= MATCH_BITS);
            wire seen_deact = code_match(next_win, ref_deact, mask_deact)
                && (run_deact >= MATCH_BITS);
            wire act_hit = cfg.det_en && rx_strobe_in[ch] && seen_act; // [RQ9]
            wire deact_hit = cfg.det_en && rx_strobe_in[ch] && seen_deact;
            wire held_low = (low_cnt == CLK_LOW_CYC);

            always_ff @(posedge clock_in) begin
                if (!rst_n_in || !cfg.det_en) begin
                    win <= 8'h00;
                    run_act <= 16'h0000;
                    run_deact <= 16'h0000;
                end else if (rx_strobe_in[ch]) begin
                    win <= next_win;
                    run_act <= run_step(run_act, per_act);
                    run_deact <= run_step(run_deact, per_deact);
                end
            end

            // transmit clock counts as held low after CLK_LOW_CYC low cycles
            always_ff @(posedge clock_in) begin
                if (!rst_n_in || tx_clock_in[ch]) low_cnt <= 8'h00;
                else if (!held_low) low_cnt <= low_cnt + 8'h01;
            end

            // status follows the codes; detection off returns it to normal
            assign next_status[ch] = !cfg.det_en ? 1'b0 : act_hit ? 1'b1 // [RQ17]
                : deact_hit ? 1'b0 : status[ch];
            // a change that lands on the clearing read still sets the bit
            assign next_irq[ch] = ((next_status[ch] != status[ch]) && mask[ch] // [RQ19]
                && cfg.det_en) || (irq[ch] && !rd_stat);
            assign clk_low[ch] = held_low;
        end
    endgenerate

    // status and interrupt registers of all channels
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            status <= `REG_RESET;
            irq <= `REG_RESET;
            loop_irq_out <= 1'b0;
        end else begin
            status <= next_status; // [RQ17]
            irq <= next_irq; // [RQ19]
            loop_irq_out <= |next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // line-side controls, all registered
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            clk_recovery_off_out <= '0;
            rx_powerdown_out <= '0;
            tx_powerdown_out <= '0;
            single_ended_term_sel_out <= '0;
        end else begin
            clk_recovery_off_out <= clk_recovery_off; // [RQ1]
            rx_powerdown_out <= rpd; // [RQ2]
            tx_powerdown_out <= next_tx_pd; // [RQ3] [RQ4]
            single_ended_term_sel_out <= term; // [RQ7]
        end
    end

    // decoder selections and their detect enables
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            excess_zero_det_en_out <= '0;
            code_violation_det_en_out <= '0;
            ami_sel_out <= '0;
            zero_sub_sel_out <= '0;
        end else begin
            excess_zero_det_en_out <= next_ezd_en; // [RQ5]
            code_violation_det_en_out <= next_cvd_en; // [RQ6]
            ami_sel_out <= mode_ok & ami_sel; // [RQ21]
            zero_sub_sel_out <= next_zero_sub; // [RQ21]
        end
    end

    // loopback outputs move in the same cycle as the status bit
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            loop_detect_status_out <= '0;
            remote_loop_out <= '0;
        end else begin
            loop_detect_status_out <= next_status; // [RQ17]
            remote_loop_out <= cfg.auto_en ? next_status : 8'h00; // [RQ10] [RQ23]
        end
    end
endmodule

// [logic/lb_regs_params.svh]
// register map, field positions and reset values of the expanded control bank
// Functional notes
// RQ1 - one clock recovery off bit per channel, 1 disables recovery, reset 0
// RQ2 - receiver n powered down while its bit is 1, reset 0
// RQ3 - transmitter powerdown bit puts driver in low-power high-Z, reset 0
// RQ4 - transmitter down when its clock is held low OR its bit set
// RQ5 - excessive zeros detect enable, zero-substitution single rail only, reset 0
// RQ6 - code violation detect off bit, inverted sense, 0 enables, reset 0
// RQ7 - termination select, 0 differential, 1 single-ended on tip only
// RQ8 - config bits 7 and 6 reserved, reset 0, keep at 0
// RQ9 - detector enable bit switches inband code detection on when 1
// RQ10 - automatic loopback enable bit turns automatic loopback on when 1
// RQ11 - activate length 00..11 selects top 5, 6, 7 or 8 code bits
// RQ12 - deactivate length 00..11 selects top 5, 6, 7 or 8 code bits
// RQ13 - config and both code registers are global for all eight channels
// RQ14 - activate code is a repeating pattern compared over selected length
// RQ15 - deactivate code is a repeating pattern compared over selected length
// RQ16 - software replicates high code bits into unused low bits
// RQ17 - detect status sets on activate code, clears on deactivate, reset 0
// RQ18 - per-channel mask bit 1 permits loopback interrupt, reset 0
// RQ19 - interrupt status sets on status change if mask and enable; read clears
// RQ20 - pointer AAH selects expanded bank, 00H primary; primary after reset
// RQ21 - AMI or zero-substitution choice acts only in single rail with recovery
// RQ22 - bit n of each per-channel register is channel n; all reset zero
// RQ23 - auto loopback: activate code enters remote loop, deactivate leaves it
`ifndef LB_REGS_PARAMS_SVH
`define LB_REGS_PARAMS_SVH
`define ADDR_POINTER 8'h1F
`define BANK_EXPANDED 8'hAA
`define BANK_PRIMARY 8'h00
`define ADDR_SINGLE_RAIL 8'h00
`define ADDR_CODE_SEL 8'h01
`define ADDR_CRS 8'h02
`define ADDR_RPD 8'h03
`define ADDR_TPD 8'h04
`define ADDR_EZD 8'h05
`define ADDR_CVD 8'h06
`define ADDR_TERM 8'h07
`define ADDR_LBCFG 8'h08
`define ADDR_ACT 8'h09
`define ADDR_DEACT 8'h0A
`define ADDR_LBSTAT 8'h0B
`define ADDR_LBMASK 8'h0C
`define ADDR_LBIRQ 8'h0D
`define REG_RESET 8'h00
`define CFG_DET_EN 5
`define CFG_AUTO_EN 4
`define CFG_ACT_LEN_HI 3
`define CFG_ACT_LEN_LO 2
`define CFG_DEACT_LEN_HI 1
`define CFG_DEACT_LEN_LO 0
`define CFG_WIDTH 6
`define MATCH_BITS_DEF 16'h0040
`define CLK_LOW_CYC_DEF 8'h10
`endif

// [logic/lb_regs_pkg.sv]
// types shared by the expanded control bank
package lb_regs_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;
    typedef struct packed {
        logic det_en;
        logic auto_en;
        logic [1:0] act_len;
        logic [1:0] deact_len;
    } loop_cfg_t;
endpackage

// [bench/host_model.sv]
// host processor model: byte-wide register accesses and code preparation
`timescale 1ns/1ps
module host_model (
    input wire logic clock_in,
    output lb_regs_pkg::host_req_t host_out
);
    import lb_regs_pkg::*;
    initial host_out = '0;
    // launched at the falling edge so the rising edge samples a settled request
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_in);
        host_out <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(negedge clock_in);
        host_out <= '0;
    endtask
    task automatic select(input logic [7:0] bank);
        access(1'b1, 8'h1F, bank);
    endtask
    // short codes need their top bits copied into the unused low bits
    function automatic logic [7:0] rep(input logic [7:0] code, input int len);
        logic [7:0] r;
        r = code;
        for (int i = len; i < 8; i++) r[7-i] = r[7-i+len];
        return r;
    endfunction
endmodule

// [bench/lb_regs_assertions.sv]
// concurrent checks on the expanded control bank ports
`timescale 1ns/1ps
module lb_regs_checker #(
    parameter logic [7:0] CLK_LOW_CYC = 8'h10
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire lb_regs_pkg::host_req_t host_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic [7:0] rx_strobe_in,
    input wire logic [7:0] tx_clock_in,
    input wire logic [7:0] tx_powerdown_out,
    input wire logic [7:0] ami_sel_out,
    input wire logic [7:0] zero_sub_sel_out,
    input wire logic [7:0] loop_detect_status_out,
    input wire logic [7:0] remote_loop_out,
    input wire logic loop_irq_out
);
    import lb_regs_pkg::*;
    logic [7:0] ptr;
    logic [7:0] low_cnt;
    // shadow of the bank pointer and a saturating low-clock run on channel 0
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ptr <= 8'h00;
            low_cnt <= 8'h00;
        end else begin
            if (host_in.wr && host_in.addr == 8'h1F) ptr <= host_in.wdata;
            low_cnt <= tx_clock_in[0] ? 8'h00 : low_cnt + 8'(low_cnt != 8'hFF);
        end
    end
    wire ext_rd = host_in.rd && ptr == 8'hAA;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////
    AST_RST_CLEAR: assert property ($rose(rst_n_in) |-> host_rdata_out == 8'h00 &&
        loop_detect_status_out == 8'h00 && !loop_irq_out && tx_powerdown_out == 8'h00)
        else $error("outputs not clear after reset");
    AST_PRIMARY_ZERO: assert property (host_in.rd && ptr != 8'hAA && host_in.addr != 8'h1F
        |=> host_rdata_out == 8'h00) else $error("primary bank read not zero");
    AST_PTR_READ: assert property (host_in.rd && !host_in.wr && host_in.addr == 8'h1F
        |=> host_rdata_out == $past(ptr)) else $error("pointer read wrong");
    AST_CFG_RSV: assert property (ext_rd && host_in.addr == 8'h08
        |=> host_rdata_out[7:6] == 2'b00) else $error("reserved config bits set");
    AST_STAT_READ: assert property (ext_rd && host_in.addr == 8'h0B
        |=> host_rdata_out == $past(loop_detect_status_out)) else $error("status read wrong");
    AST_IRQ_CLEAR: assert property (ext_rd && host_in.addr == 8'h0B && rx_strobe_in == 8'h00
        |=> !loop_irq_out) else $error("interrupt not cleared by status read");
    AST_STAT_CAUSE: assert property ((loop_detect_status_out & ~$past(loop_detect_status_out)
        & ~$past(rx_strobe_in)) == 8'h00) else $error("status rose without a strobe");
    AST_IRQ_CAUSE: assert property ($rose(loop_irq_out) |->
        loop_detect_status_out != $past(loop_detect_status_out)) else $error("irq without change");
    AST_REMOTE_GATED: assert property ((remote_loop_out & ~loop_detect_status_out) == 8'h00)
        else $error("remote loop without detect");
    AST_MODE_EXCL: assert property ((ami_sel_out & zero_sub_sel_out) == 8'h00)
        else $error("both decoders selected");
    AST_TX_LOW: assert property (low_cnt > CLK_LOW_CYC + 8'h01 |-> tx_powerdown_out[0])
        else $error("held-low clock did not power down");
    cover property ($rose(loop_detect_status_out[0]));
    cover property ($rose(loop_irq_out));
    cover property ($rose(tx_powerdown_out[0]));
endmodule
bind expanded_ctrl_inband_loopback_regs lb_regs_checker #(.CLK_LOW_CYC(CLK_LOW_CYC)) checks (
    .clock_in, .rst_n_in, .host_in, .host_rdata_out, .rx_strobe_in, .tx_clock_in,
    .tx_powerdown_out, .ami_sel_out, .zero_sub_sel_out, .loop_detect_status_out,
    .remote_loop_out, .loop_irq_out);

// [bench/expanded_ctrl_inband_loopback_regs_tb.sv]
// self-checking bench for the expanded control bank
`timescale 1ns/1ps
module expanded_ctrl_inband_loopback_regs_tb;
    import lb_regs_pkg::*;
    logic clock_in, rst_n_in, irq_o;
    host_req_t host_in;
    logic [7:0] host_rdata_out, rx_data_in, rx_strobe_in, tx_clock_in, v;
    logic [7:0] crs_o, rpd_o, tpd_o, ezd_o, cvd_o, term_o, ami_o, zs_o, st_o, rl_o;
    logic [7:0] exp_q[$];
    logic [7:0] w[9];
    logic [7:0] regs[9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0C};
    int n_fail = 0, n_compared = 0, cycles = 0, seed = 6;
    host_model host (.clock_in(clock_in), .host_out(host_in));
    expanded_ctrl_inband_loopback_regs #(.MATCH_BITS(16'h0004), .CLK_LOW_CYC(8'h02)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .host_in(host_in),
        .host_rdata_out(host_rdata_out), .rx_data_in(rx_data_in), .rx_strobe_in(rx_strobe_in),
        .tx_clock_in(tx_clock_in), .clk_recovery_off_out(crs_o), .rx_powerdown_out(rpd_o),
        .tx_powerdown_out(tpd_o), .excess_zero_det_en_out(ezd_o),
        .code_violation_det_en_out(cvd_o), .single_ended_term_sel_out(term_o),
        .ami_sel_out(ami_o), .zero_sub_sel_out(zs_o), .loop_detect_status_out(st_o),
        .remote_loop_out(rl_o), .loop_irq_out(irq_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask
    // four periods of a code, first bit MSB, on all channels at once
    task automatic feed(input logic [7:0] code, input int len);
        for (int r = 0; r < 4 * len; r++) begin
            @(negedge clock_in);
            rx_data_in = {8{code[7 - (r % len)]}};
            rx_strobe_in = 8'hFF;
        end
        @(negedge clock_in);
        rx_strobe_in = 8'h00;
        rx_data_in = ~rx_data_in;
        @(negedge clock_in);
    endtask
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            end_sim();
        end
    end
    // read data lands on the edge that takes the strobe
    always @(posedge clock_in) begin
        if (host_in.rd === 1'b1) begin
            @(negedge clock_in);
            check(host_rdata_out, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_in = 1'b0;
        rx_data_in = 8'h00;
        rx_strobe_in = 8'h00;
        tx_clock_in = 8'hFF;
        repeat (5) @(negedge clock_in);
        rst_n_in = 1'b1;
        wr(8'h03, 8'hFF);
        rd(8'h03, 8'h00);
        rd(8'h1F, 8'h00);
        host.select(8'hAA);
        for (int a = 2; a <= 12; a++) rd(8'(a), 8'h00);
        $display("reset and bank test done");
        foreach (regs[i]) begin
            w[i] = 8'($random(seed));
            wr(regs[i], w[i]);
            rd(regs[i], w[i]);
        end
        check(crs_o, w[0]);
        check(rpd_o, w[1]);
        check(tpd_o, w[2]);
        check(term_o, w[5]);
        wr(8'h08, 8'hFF);
        rd(8'h08, 8'h3F);
        wr(8'h0B, 8'hFF);
        wr(8'h08, 8'h00);
        rd(8'h0B, 8'h00);
        $display("read write test done");
        wr(8'h00, 8'hFF);
        wr(8'h01, 8'h0F);
        wr(8'h02, 8'h00);
        wr(8'h05, 8'hFF);
        wr(8'h06, 8'h33);
        @(negedge clock_in);
        check(ami_o, 8'h0F);
        check(zs_o, 8'hF0);
        check(ezd_o, 8'hF0);
        check(cvd_o, 8'hC0);
        wr(8'h02, 8'hFF);
        @(negedge clock_in);
        check(ezd_o | cvd_o | ami_o | zs_o, 8'h00);
        $display("decoder mode test done");
        v = 8'($random(seed)) & 8'hFE;
        wr(8'h04, 8'h00);
        tx_clock_in = v;
        repeat (5) @(negedge clock_in);
        check(tpd_o, ~v);
        tx_clock_in = 8'hFF;
        repeat (2) @(negedge clock_in);
        check(tpd_o, 8'h00);
        $display("transmit clock test done");
        wr(8'h0C, 8'hFF);
        wr(8'h09, 8'h80);
        wr(8'h08, 8'h1F);
        feed(8'h80, 8);
        check(st_o, 8'h00);
        for (int l = 0; l < 4; l++) begin
            wr(8'h09, host.rep(8'h80, l + 5));
            wr(8'h0A, host.rep(8'hC0, l + 5));
            wr(8'h08, 8'(8'h30 | (l << 2) | l));
            feed(host.rep(8'h80, l + 5), l + 5);
            check(st_o, 8'hFF);
            check(rl_o, 8'hFF);
            check({7'h00, irq_o}, 8'h01);
            rd(8'h0D, 8'hFF);
            rd(8'h0B, 8'hFF);
            check({7'h00, irq_o}, 8'h00);
            feed(host.rep(8'hC0, l + 5), l + 5);
            check(st_o | rl_o, 8'h00);
            rd(8'h0B, 8'h00);
        end
        wr(8'h0C, 8'h0F);
        wr(8'h08, 8'h2F);
        feed(8'h80, 8);
        check(st_o, 8'hFF);
        check(rl_o, 8'h00);
        rd(8'h0D, 8'h0F);
        $display("loop code test done");
        end_sim();
    end
endmodule
